// ### verilog/sptg_pkg.sv
// Constants, register map and types for the steering program transition guard.
// Assumes a single 250 MHz clock and an APB master with 32-bit data.
package sptg_pkg;

  localparam int          NUM_DEV        = 4;
  localparam int          PROG_W         = 8;
  localparam int          SPEED_W        = 10;
  localparam int          POS_W          = 16;
  localparam int          ERR_DEPTH      = 8;
  localparam int          ERR_AW         = 3;
  localparam int          ERR_W          = 16;

  // Program number ranges per steering device
  localparam logic [7:0]  PROG_BASE_WHEEL = 8'h00;
  localparam logic [7:0]  PROG_LAST_WHEEL = 8'h09;
  localparam logic [7:0]  PROG_BASE_HIGH  = 8'h14;
  localparam logic [7:0]  PROG_LAST_HIGH  = 8'h18;
  localparam logic [7:0]  PROG_BASE_LOW   = 8'h19;
  localparam logic [7:0]  PROG_LAST_LOW   = 8'h1D;
  localparam logic [7:0]  PROG_BASE_SETPT = 8'h1E;
  localparam logic [7:0]  PROG_LAST_SETPT = 8'h22;

  localparam logic [9:0]  SPEED_THR_RESET = 10'h032;
  localparam logic [9:0]  SPEED_THR_MAX   = 10'h3E8;
  localparam logic [15:0] NEUTRAL_BAND_RESET = 16'h0010;
  localparam logic [15:0] RIGHT_LIMIT_RESET  = 16'h8000;
  localparam logic [15:0] LEFT_LIMIT_RESET   = 16'h7FFF;

  // Timing
  localparam int          CLOCK_MHZ      = 250;
  localparam int          SWITCH_MAX_MS  = 50;
  localparam int          SWITCH_MAX_CYC = SWITCH_MAX_MS * 1000 * CLOCK_MHZ;
  localparam int          REPORT_MS      = 10;
  localparam int          REPORT_CYC     = REPORT_MS * 1000 * CLOCK_MHZ;

  // APB byte addresses
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_STATE     = 8'h04;
  localparam logic [7:0]  ADDR_THR_BASE  = 8'h08;
  localparam logic [7:0]  ADDR_RIGHT_LIM = 8'h18;
  localparam logic [7:0]  ADDR_LEFT_LIM  = 8'h1C;
  localparam logic [7:0]  ADDR_NEUTRAL   = 8'h20;
  localparam logic [7:0]  ADDR_ACTIVE    = 8'h24;
  localparam logic [7:0]  ADDR_INT_STAT  = 8'h28;
  localparam logic [7:0]  ADDR_INT_EN    = 8'h2C;
  localparam logic [7:0]  ADDR_INT_CLR   = 8'h30;
  localparam logic [7:0]  ADDR_ERR_SEL   = 8'h34;
  localparam logic [7:0]  ADDR_ERR_DATA  = 8'h38;

  // Control and interrupt bit positions
  localparam int          CTRL_RUN       = 0;
  localparam int          CTRL_SAVE      = 1;
  localparam int          INT_ACCEPT     = 0;
  localparam int          INT_REJECT     = 1;
  localparam int          INT_FAULT      = 2;
  localparam int          INT_W          = 3;

  typedef enum logic [1:0] {
    SPTG_IDLE  = 2'b00,
    SPTG_EVAL  = 2'b01,
    SPTG_REPLY = 2'b10
  } sptg_req_st_t;

  typedef enum logic [1:0] {
    SPTG_GREEN  = 2'b00,
    SPTG_YELLOW = 2'b01,
    SPTG_RED    = 2'b10
  } sptg_led_t;

endpackage

// ### verilog/sptg_tick.sv
// One-cycle enable pulse every PERIOD clocks.
// Assumes a synchronous active-high reset on the same clock.
`timescale 1ns/100ps
module sptg_tick #(
  parameter int PERIOD = 16
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  wire         last = (cnt_q == 32'(PERIOD - 1));

  assign cnt_d = last ? 32'h0000_0000 : cnt_q + 32'h0000_0001;

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_q <= 32'h0000_0000;
    else
      cnt_q <= cnt_d;
  end

  assign tick = last;
endmodule // sptg_tick

// ### verilog/sptg_guard.sv
// Steering program transition guard: APB registers, request checker,
// state indicator, periodic report and fault store.
// Condition and fault inputs come from logic on CLOCK, so they pass no synchroniser.
`timescale 1ns/100ps
module sptg_guard
  import sptg_pkg::*;
#(
  parameter int SWITCH_CYC = SWITCH_MAX_CYC,
  parameter int REPORT_PERIOD = REPORT_CYC
) (
  input  wire logic                    CLOCK,
  input  wire logic                    SYS_RST,
  // APB slave
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [7:0]              PADDR,
  input  wire logic [31:0]             PWDATA,
  output logic      [31:0]             PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  output logic                         IRQ,
  // Program switch request and reply
  input  wire logic                    REQ_VALID,
  input  wire logic [PROG_W-1:0]       REQ_PROGRAM,
  output logic                         REQ_READY,
  output logic                         REPLY_VALID,
  output logic      [PROG_W-1:0]       REPLY_PROGRAM,
  // Operating state report
  output logic                         REPORT_VALID,
  output logic      [4*PROG_W-1:0]     REPORT_PROGRAMS,
  output logic      [1:0]              REPORT_STATE,
  // Conditions
  input  wire logic                    SPEED_PRESENT,
  input  wire logic [SPEED_W-1:0]      VEHICLE_SPEED,
  input  wire logic signed [POS_W-1:0] SPOOL_POSITION,
  input  wire logic signed [POS_W-1:0] ACTUATOR_POSITION,
  // Faults
  input  wire logic                    MAJOR_FAULT,
  input  wire logic                    CRITICAL_FAULT,
  input  wire logic                    FAULT_LOG_VALID,
  input  wire logic [ERR_W-1:0]        FAULT_LOG_CODE,
  // Outputs to valve and diagnostics
  output logic                         VALVE_ENABLE,
  output logic                         DIAG_ENABLE,
  output logic                         DIAG_VALID,
  output logic      [ERR_W-1:0]        DIAG_CODE,
  output logic                         LED_GREEN,
  output logic                         LED_YELLOW,
  output logic                         LED_RED
);

  function automatic logic prog_in_range(input logic [PROG_W-1:0] p);
    prog_in_range = (p <= PROG_LAST_WHEEL) ||
                    (p >= PROG_BASE_HIGH && p <= PROG_LAST_SETPT);
  endfunction

  function automatic logic [1:0] prog_device(input logic [PROG_W-1:0] p);
    if (p <= PROG_LAST_WHEEL)
      prog_device = 2'd0;
    else if (p <= PROG_LAST_HIGH)
      prog_device = 2'd1;
    else if (p <= PROG_LAST_LOW)
      prog_device = 2'd2;
    else
      prog_device = 2'd3;
  endfunction

  localparam logic [PROG_W-1:0] PROG_BASE [NUM_DEV] =
    '{PROG_BASE_WHEEL, PROG_BASE_HIGH, PROG_BASE_LOW, PROG_BASE_SETPT};

  // Registers
  logic [1:0]              ctrl_q;
  logic [SPEED_W-1:0]      thr_q [NUM_DEV];
  logic signed [POS_W-1:0] right_lim_q;
  logic signed [POS_W-1:0] left_lim_q;
  logic [POS_W-1:0]        neutral_q;
  logic [PROG_W-1:0]       active_q [NUM_DEV];
  logic [INT_W-1:0]        int_stat_q;
  logic [INT_W-1:0]        int_en_q;
  logic [ERR_AW-1:0]       err_sel_q;
  logic [ERR_AW-1:0]       err_wr_q;
  logic [ERR_W-1:0]        err_mem [ERR_DEPTH];
  logic                    crit_q;
  logic                    major_q;

  sptg_req_st_t            st_q;
  sptg_req_st_t            st_d;
  logic [PROG_W-1:0]       req_prog_q;
  logic                    accept_q;

  // APB decode
  wire       apb_wr    = PSEL && PENABLE && PWRITE;
  wire       apb_rd    = PSEL && !PWRITE;
  wire [3:0] thr_slot  = 4'(PADDR[7:2] - ADDR_THR_BASE[7:2]);
  // Unaligned offsets inside the threshold span must not alias a slot
  wire       hit_thr   = (PADDR >= ADDR_THR_BASE) && (PADDR < ADDR_RIGHT_LIM) &&
                         (PADDR[1:0] == 2'b00);
  wire       addr_ok   = (PADDR[1:0] == 2'b00) && (PADDR <= ADDR_ERR_DATA);

  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;

  // Indicator state
  sptg_led_t led;
  assign led = crit_q ? SPTG_RED :
               (major_q || !ctrl_q[CTRL_RUN] || ctrl_q[CTRL_SAVE]) ? SPTG_YELLOW :
               SPTG_GREEN;
  assign LED_GREEN    = (led == SPTG_GREEN);
  assign LED_YELLOW   = (led == SPTG_YELLOW);
  assign LED_RED      = (led == SPTG_RED);
  assign VALVE_ENABLE = (led == SPTG_GREEN);
  assign DIAG_ENABLE  = (led != SPTG_RED);

  // Transition conditions for the held request
  wire [1:0] req_dev   = prog_device(req_prog_q);
  wire [POS_W-1:0] spool_mag = SPOOL_POSITION[POS_W-1] ? POS_W'(-SPOOL_POSITION)
                                                       : POS_W'(SPOOL_POSITION);
  wire cond_speed  = !SPEED_PRESENT || (VEHICLE_SPEED <= thr_q[req_dev]);
  wire cond_spool  = (spool_mag <= neutral_q);
  wire cond_pos    = (ACTUATOR_POSITION >= right_lim_q) &&
                     (ACTUATOR_POSITION <= left_lim_q);
  wire cond_all    = cond_speed && cond_spool && cond_pos &&
                     prog_in_range(req_prog_q) && !crit_q;

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      SPTG_IDLE:  st_d = REQ_VALID ? SPTG_EVAL : SPTG_IDLE;
      SPTG_EVAL:  st_d = SPTG_REPLY;
      SPTG_REPLY: st_d = SPTG_IDLE;
      default:    st_d = SPTG_IDLE;
    endcase
  end

  assign REQ_READY = (st_q == SPTG_IDLE);

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      st_q       <= SPTG_IDLE;
      req_prog_q <= 8'h00;
      accept_q   <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      if (REQ_VALID && REQ_READY)
        req_prog_q <= REQ_PROGRAM;
      if (st_q == SPTG_EVAL)
        accept_q <= cond_all;
    end
  end

  // Active programs, one per steering device
  genvar g;
  generate
    for (g = 0; g < NUM_DEV; g++)
    begin : g_dev
      wire thr_wr = apb_wr && hit_thr && (thr_slot == 4'(g));
      always_ff @(posedge CLOCK)
      begin
        if (SYS_RST)
        begin
          active_q[g] <= PROG_BASE[g];
          thr_q[g]    <= SPEED_THR_RESET;
        end
        else
        begin
          if (st_q == SPTG_EVAL && cond_all && req_dev == 2'(g))
            active_q[g] <= req_prog_q;
          if (thr_wr && PWDATA[15:0] <= 16'(SPEED_THR_MAX))
            thr_q[g] <= PWDATA[SPEED_W-1:0];
        end
      end
      assign REPORT_PROGRAMS[g*PROG_W +: PROG_W] = active_q[g];
    end
  endgenerate

  // Reply, silenced when red
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      REPLY_VALID   <= 1'b0;
      REPLY_PROGRAM <= 8'h00;
    end
    else
    begin
      REPLY_VALID <= (st_q == SPTG_EVAL) && cond_all;
      if (st_q == SPTG_EVAL)
        REPLY_PROGRAM <= req_prog_q;
    end
  end

  // Periodic report
  logic report_tick;
  sptg_tick #(.PERIOD(REPORT_PERIOD)) u_report_tick (
    .clk  (CLOCK),
    .rst  (SYS_RST),
    .tick (report_tick)
  );

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      REPORT_VALID <= 1'b0;
      REPORT_STATE <= 2'b00;
    end
    else
    begin
      REPORT_VALID <= report_tick && DIAG_ENABLE;
      REPORT_STATE <= led;
    end
  end

  // Fault latches, held until reset; a critical fault never clears on its own
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      crit_q  <= 1'b0;
      major_q <= 1'b0;
    end
    else
    begin
      crit_q  <= crit_q || CRITICAL_FAULT;
      major_q <= major_q || MAJOR_FAULT;
    end
  end

  // Persistent fault store, readable at any time, sendable only while yellow
  wire err_sel_wr = apb_wr && (PADDR == ADDR_ERR_SEL);
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      err_wr_q   <= 3'h0;
      err_sel_q  <= 3'h0;
      DIAG_VALID <= 1'b0;
      DIAG_CODE  <= 16'h0000;
    end
    else
    begin
      if (FAULT_LOG_VALID)
      begin
        err_mem[err_wr_q] <= FAULT_LOG_CODE;
        err_wr_q          <= err_wr_q + 3'h1;
      end
      if (err_sel_wr)
        err_sel_q <= PWDATA[ERR_AW-1:0];
      DIAG_VALID <= err_sel_wr && LED_YELLOW;
      if (err_sel_wr && LED_YELLOW)
        DIAG_CODE <= err_mem[PWDATA[ERR_AW-1:0]];
    end
  end

  // Control, limits and interrupts
  wire [INT_W-1:0] int_set = {CRITICAL_FAULT || MAJOR_FAULT,
                              (st_q == SPTG_EVAL) && !cond_all,
                              (st_q == SPTG_EVAL) && cond_all};
  wire [INT_W-1:0] int_clr = (apb_wr && PADDR == ADDR_INT_CLR) ? PWDATA[INT_W-1:0] : 3'h0;

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      ctrl_q      <= 2'b00;
      right_lim_q <= RIGHT_LIMIT_RESET;
      left_lim_q  <= LEFT_LIMIT_RESET;
      neutral_q   <= NEUTRAL_BAND_RESET;
      int_stat_q  <= 3'h0;
      int_en_q    <= 3'h0;
    end
    else
    begin
      if (apb_wr && PADDR == ADDR_CTRL)
        ctrl_q <= PWDATA[1:0];
      if (apb_wr && PADDR == ADDR_RIGHT_LIM)
        right_lim_q <= PWDATA[POS_W-1:0];
      if (apb_wr && PADDR == ADDR_LEFT_LIM)
        left_lim_q <= PWDATA[POS_W-1:0];
      if (apb_wr && PADDR == ADDR_NEUTRAL)
        neutral_q <= PWDATA[POS_W-1:0];
      if (apb_wr && PADDR == ADDR_INT_EN)
        int_en_q <= PWDATA[INT_W-1:0];
      // Set wins over a clear in the same cycle
      int_stat_q <= (int_stat_q & ~int_clr) | int_set;
    end
  end

  assign IRQ = |(int_stat_q & int_en_q);

  // Read mux
  logic [31:0] rd_data;
  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (hit_thr)
      rd_data = 32'(thr_q[thr_slot[1:0]]);
    else
      case (PADDR)
        ADDR_CTRL:      rd_data = 32'(ctrl_q);
        ADDR_STATE:     rd_data = {28'h000_0000, accept_q, crit_q, 2'(led)};
        ADDR_RIGHT_LIM: rd_data = 32'(unsigned'(right_lim_q));
        ADDR_LEFT_LIM:  rd_data = 32'(unsigned'(left_lim_q));
        ADDR_NEUTRAL:   rd_data = 32'(neutral_q);
        ADDR_ACTIVE:    rd_data = REPORT_PROGRAMS;
        ADDR_INT_STAT:  rd_data = 32'(int_stat_q);
        ADDR_INT_EN:    rd_data = 32'(int_en_q);
        ADDR_ERR_SEL:   rd_data = 32'(err_sel_q);
        ADDR_ERR_DATA:  rd_data = 32'(err_mem[err_sel_q]);
        default:        rd_data = 32'h0000_0000;
      endcase
  end
  assign PRDATA = apb_rd ? rd_data : 32'h0000_0000;

  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  sequence s_take;
    REQ_VALID && REQ_READY;
  endsequence

  sequence s_eval_ok;
    (st_q == SPTG_EVAL) && cond_all;
  endsequence

  a_switch_deadline: assert property (s_take |-> ##2 (st_q == SPTG_REPLY))
    else $error("request not decided within two cycles");
  a_apply_needs_cond: assert property (
    (st_q == SPTG_EVAL) && !(cond_speed && cond_spool && cond_pos)
    |=> !REPLY_VALID)
    else $error("switch applied with a failed condition");
  a_speed_gate: assert property ((st_q == SPTG_EVAL) && SPEED_PRESENT &&
    VEHICLE_SPEED > thr_q[req_dev] |=> !REPLY_VALID)
    else $error("switch applied above speed threshold");
  a_thr_range: assert property (thr_q[0] <= SPEED_THR_MAX &&
    thr_q[1] <= SPEED_THR_MAX && thr_q[2] <= SPEED_THR_MAX && thr_q[3] <= SPEED_THR_MAX)
    else $error("speed threshold out of range");
  a_no_speed_ok: assert property (!SPEED_PRESENT |-> cond_speed)
    else $error("absent speed blocked a switch");
  a_spool_gate: assert property ((st_q == SPTG_EVAL) &&
    spool_mag > neutral_q |=> !REPLY_VALID)
    else $error("switch applied with spool away from neutral");
  a_limit_gate: assert property ((st_q == SPTG_EVAL) &&
    (ACTUATOR_POSITION < right_lim_q || ACTUATOR_POSITION > left_lim_q) |=> !REPLY_VALID)
    else $error("switch applied outside travel limits");
  a_reject_keeps: assert property ((st_q == SPTG_EVAL) && !cond_all |=>
    REPORT_PROGRAMS == $past(REPORT_PROGRAMS))
    else $error("rejected request changed a program");
  a_reply_follows: assert property (s_eval_ok |=>
    REPLY_VALID && REPLY_PROGRAM == $past(req_prog_q) && active_q[$past(req_dev)] == REPLY_PROGRAM)
    else $error("accepted switch without matching reply");
  a_report_period: assert property (report_tick && DIAG_ENABLE |=> REPORT_VALID)
    else $error("periodic report missing");
  a_green_valves: assert property (LED_GREEN == VALVE_ENABLE)
    else $error("green indicator disagrees with valve enable");
  a_yellow_diag: assert property (LED_YELLOW |-> !VALVE_ENABLE && DIAG_ENABLE)
    else $error("yellow state with valves or diagnostics wrong");
  a_red_silent: assert property ($rose(crit_q) |-> LED_RED && !VALVE_ENABLE &&
    !DIAG_ENABLE ##1 !REPORT_VALID && !DIAG_VALID && !REPLY_VALID)
    else $error("critical fault did not silence the block");
  a_diag_send: assert property (err_sel_wr && LED_YELLOW |=>
    DIAG_VALID && DIAG_CODE == err_mem[$past(PWDATA[ERR_AW-1:0])])
    else $error("fault detail not sent while yellow");
  a_power_up: assert property ($fell(SYS_RST) |->
    active_q[0] == PROG_BASE_WHEEL && active_q[1] == PROG_BASE_HIGH)
    else $error("lowest programs not active after reset");
  a_range_reject: assert property ((st_q == SPTG_EVAL) &&
    !prog_in_range(req_prog_q) |=> !REPLY_VALID)
    else $error("out of range program accepted");

endmodule // sptg_guard

// ### test/sptg_host_model.sv
// Host requester model for the program switch handshake.
// Assumes send is entered just after a rising clock edge.
`timescale 1ns/100ps
module sptg_host_model
  import sptg_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              req_ready,
  output logic                   req_valid,
  output logic      [PROG_W-1:0] req_program
);
  initial
  begin
    req_valid   = 1'b0;
    req_program = 8'hA5;
  end

  task automatic send(input logic [PROG_W-1:0] prog);
    req_valid   <= 1'b1;
    req_program <= prog;
    do
      @(posedge clk);
    while (req_ready !== 1'b1);
    req_valid   <= 1'b0;
    // Released number must not echo the old one
    req_program <= ~prog;
  endtask
endmodule // sptg_host_model

// ### test/testbench.sv
// Self-checking bench for the steering program transition guard.
// Assumes sptg_pkg and the host requester model are compiled first.
`timescale 1ns/100ps
module testbench
  import sptg_pkg::*;
;
  logic        clock = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, reply_program, req_program;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, act, rep_prog, report_programs;
  logic        pready, pslverr, err, irq, req_valid, req_ready, reply_valid, report_valid;
  logic        spd_on = 1'b0, major = 1'b0, critical = 1'b0, log_valid = 1'b0;
  logic        valve_en, diag_en, diag_valid, led_g, led_y, led_r;
  logic [1:0]  report_state;
  logic [9:0]  speed = 10'h000;
  logic [15:0] spool = 16'h0000, pos = 16'h0000, log_code = 16'h5A3C, diag_code, diag_seen;
  int          n_mismatch = 0, check_count = 0, n_rep = 0, n_diag = 0, k;

  sptg_guard #(.REPORT_PERIOD(16)) dut_u (
    .CLOCK(clock), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .IRQ(irq), .REQ_VALID(req_valid), .REQ_PROGRAM(req_program), .REQ_READY(req_ready),
    .REPLY_VALID(reply_valid), .REPLY_PROGRAM(reply_program), .REPORT_VALID(report_valid),
    .REPORT_PROGRAMS(report_programs), .REPORT_STATE(report_state), .SPEED_PRESENT(spd_on),
    .VEHICLE_SPEED(speed), .SPOOL_POSITION(spool), .ACTUATOR_POSITION(pos),
    .MAJOR_FAULT(major), .CRITICAL_FAULT(critical), .FAULT_LOG_VALID(log_valid),
    .FAULT_LOG_CODE(log_code), .VALVE_ENABLE(valve_en), .DIAG_ENABLE(diag_en),
    .DIAG_VALID(diag_valid), .DIAG_CODE(diag_code), .LED_GREEN(led_g),
    .LED_YELLOW(led_y), .LED_RED(led_r)
  );

  sptg_host_model host_u (
    .clk(clock), .req_ready(req_ready), .req_valid(req_valid), .req_program(req_program)
  );

  always #2 clock = ~clock;

  always @(posedge clock)
  begin
    if (report_valid === 1'b1)
    begin
      n_rep    <= n_rep + 1;
      rep_prog <= report_programs;
    end
    if (diag_valid === 1'b1)
    begin
      n_diag    <= n_diag + 1;
      diag_seen <= diag_code;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  // Reply counted over a window, then the active set compared
  task automatic req(input logic [7:0] p, input logic ok);
    int         n = 0;
    logic [7:0] got = 8'h00;
    host_u.send(p);
    repeat (4)
    begin
      @(posedge clock);
      if (reply_valid === 1'b1)
      begin
        n++;
        got = reply_program;
      end
    end
    if (ok)
      act[(p < 8'h0A ? 0 : p < 8'h19 ? 1 : p < 8'h1E ? 2 : 3) * 8 +: 8] = p;
    chk(n, ok);
    chk(got, ok ? p : 8'h00);
    chk(report_programs, act);
  endtask

  task automatic t_reset;
    chk(report_programs, act);
    chk({led_g, led_y, led_r, valve_en, diag_en}, 5'b01001);
    apb(1'b0, ADDR_THR_BASE, 32'h0000_0000);
    chk(rd, 32'h0000_0032);
    apb(1'b0, 8'h3C, 32'h0000_0000);
    chk({err, rd}, 33'h1_0000_0000);
    $display("reset test done");
  endtask

  task automatic t_accept;
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    chk({led_g, led_y, led_r, valve_en}, 4'b1001);
    req(8'h03, 1'b1);
    req(8'h09, 1'b1);
    repeat (20) @(posedge clock);
    chk(rep_prog, act);
    chk(report_state, 2'b00);
    apb(1'b1, ADDR_CTRL, 32'h0000_0003);
    chk({led_g, led_y, valve_en}, 3'b010);
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    $display("accept test done");
  endtask

  task automatic t_cond;
    spd_on <= 1'b1;
    speed  <= 10'h032;
    req(8'h15, 1'b1);
    speed  <= 10'h033;
    req(8'h16, 1'b0);
    apb(1'b1, ADDR_THR_BASE + 8'h04, 32'h0000_03E8);
    apb(1'b1, ADDR_THR_BASE + 8'h04, 32'h0000_03E9);
    apb(1'b0, ADDR_THR_BASE + 8'h04, 32'h0000_0000);
    chk(rd, 32'h0000_03E8);
    req(8'h16, 1'b1);
    spd_on <= 1'b0;
    speed  <= 10'h3FF;
    req(8'h05, 1'b1);
    spool  <= 16'h0011;
    req(8'h06, 1'b0);
    spool  <= 16'hFFF0;
    req(8'h06, 1'b1);
    apb(1'b1, ADDR_LEFT_LIM, 32'h0000_0064);
    pos    <= 16'h0065;
    req(8'h1A, 1'b0);
    pos    <= 16'h0064;
    req(8'h1A, 1'b1);
    req(8'h0A, 1'b0);
    req(8'h23, 1'b0);
    $display("condition test done");
  endtask

  task automatic t_irq;
    apb(1'b1, ADDR_INT_CLR, 32'h0000_0007);
    apb(1'b1, ADDR_INT_EN, 32'h0000_0002);
    chk(irq, 1'b0);
    req(8'h13, 1'b0);
    chk(irq, 1'b1);
    apb(1'b0, ADDR_INT_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    apb(1'b1, ADDR_INT_CLR, 32'h0000_0002);
    chk(irq, 1'b0);
    apb(1'b1, ADDR_INT_EN, 32'h0000_0001);
    req(8'h0B, 1'b0);
    chk(irq, 1'b0);
    req(8'h07, 1'b1);
    chk(irq, 1'b1);
    apb(1'b0, ADDR_STATE, 32'h0000_0000);
    chk(rd, 32'h0000_0008);
    $display("interrupt test done");
  endtask

  task automatic t_fault;
    // Same code in every slot, so the ring position does not matter
    log_valid <= 1'b1;
    repeat (8) @(posedge clock);
    log_valid <= 1'b0;
    major     <= 1'b1;
    repeat (2) @(posedge clock);
    chk({led_g, led_y, led_r, valve_en, diag_en}, 5'b01001);
    apb(1'b0, ADDR_INT_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0007);
    apb(1'b1, ADDR_ERR_SEL, 32'h0000_0003);
    repeat (2) @(posedge clock);
    chk(n_diag, 1);
    chk(diag_seen, 16'h5A3C);
    apb(1'b0, ADDR_ERR_DATA, 32'h0000_0000);
    chk(rd, 32'h0000_5A3C);
    critical <= 1'b1;
    // Indicator code is registered, one edge behind the lamps
    repeat (3) @(posedge clock);
    chk({led_g, led_y, led_r, valve_en, diag_en}, 5'b00100);
    chk(report_state, 2'b10);
    req(8'h01, 1'b0);
    k = n_rep;
    apb(1'b1, ADDR_ERR_SEL, 32'h0000_0001);
    repeat (40) @(posedge clock);
    chk(n_rep - k, 0);
    chk(n_diag, 1);
    $display("fault test done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (4000) @(posedge clock);
    n_mismatch++;
    wrap_up();
  end

  initial
  begin
    act = 32'h1E19_1400;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_accept();
    t_cond();
    t_irq();
    t_fault();
    wrap_up();
  end
endmodule // testbench
